// ===== edram_host.sv
// Host controller that drives an EDO DRAM through its strobe pins
// Behaviour
// R1: Row 11 bits, column 10 bits, multiplexed.
// R2: Wait 200 us, eight refreshes first.
// R3: Initialisation refreshes are all CAS-before-RAS.
// R4: Write strobe before column strobe: early write.
// R5: Late write strobe gives read-modify-write.
// R6: Undefined data timing never relied upon.
// R7: Write data held around the write edge.
// R8: Write strobe low at least 10 ns.
// R9: Output enable off before driving write data; in read-modify-write OE goes off on the same edge the data drive starts.
// R10: Read data sampled after longest access.
// R11: Memory drives data until strobes rise.
// R12: Minimum page cycle only for uniform runs.
// R13: Write strobe high through read cycles.
// R14: CAS 5 ns before RAS, held 10 ns.
// R15: Self refresh: RAS, CAS low 100 us.
// R16: No RAS pulse between 10 and 100 us.
// R17: Longer precharge after self refresh.
// R18: Burst refresh users: 2048 CBR around sleep.
// R19: Distributed users: one CBR within 15.6 us.
// R20: Full refresh between self refresh periods.
// R21: RAS-only refresh: row address, no column.
// R22: All 2048 rows per refresh period; a RAS-only refresh here always strobes the row of the last access.
module edram_host
   import edram_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC,
   parameter int SREF_CYCLES = SREF_ENTRY_CYC
) (
   input wire logic sys_clk, // System clock, 10 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic req_valid, // Access request
   input wire edram_op_e req_op, // Read, write or read-modify-write
   input wire logic [ROW_W+COL_W-1:0] req_addr, // Row in high bits
   input wire logic [DATA_W-1:0] req_wdata, // Write data
   output logic req_ready, // Request taken this cycle
   output logic [DATA_W-1:0] rd_data, // Read data
   output logic rd_valid, // Read data pulse
   input wire logic ref_req, // Refresh request from the user timer
   input wire logic ref_ras_only, // Use RAS-only instead of CBR
   output logic ref_ack, // Refresh done pulse
   input wire logic sref_req, // Hold in self refresh while high
   output logic sref_active, // In self refresh
   output logic init_done, // Power-up sequence complete
   output logic ras_n, // Row strobe
   output logic cas_n, // Column strobe
   output logic we_n, // Write strobe
   output logic oe_n, // Output enable
   output logic [ADDR_W-1:0] addr, // Multiplexed address
   input wire logic [DATA_W-1:0] dq_in, // Data pins in
   output logic [DATA_W-1:0] dq_out, // Data pins out
   output logic dq_oe // High while host drives data
);
   edram_state_e state_reg;
   edram_op_e op_reg;
   logic [ROW_W+COL_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
   logic [3:0] init_cnt_reg;
   logic ras_only_reg;
   logic tload;
   logic [CNT_W-1:0] tcount;
   logic tdone;
   logic sleep_reg;
   // Read data crosses the two-flop synchroniser before it can be taken
   localparam int SYNC_CYC = 2;

   // ========================================
   // Pin input synchroniser
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dq_s1_reg <= '0;
         dq_s2_reg <= '0;
      end else begin
         dq_s1_reg <= dq_in;
         dq_s2_reg <= dq_s1_reg;
      end
   end

   edram_timer #(.W(CNT_W)) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   // ========================================
   // Sequencer
   assign req_ready = (state_reg == EDRAM_S_IDLE) && tdone && !ref_req
      && !sref_req && req_valid;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= EDRAM_S_PWRUP;
         op_reg <= EDRAM_OP_READ;
         addr_reg <= '0;
         wdata_reg <= '0;
         init_cnt_reg <= 4'h0;
         ras_only_reg <= 1'b0;
         sleep_reg <= 1'b0;
         init_done <= 1'b0;
         tload <= 1'b1;
         tcount <= CNT_W'(PWRUP_CYCLES); // R2
      end else begin
         tload <= 1'b0;
         case (state_reg)
            EDRAM_S_PWRUP: begin
               if (tdone) begin
                  state_reg <= EDRAM_S_CBR_C;
                  tload <= 1'b1;
                  tcount <= CNT_W'(CSR_CYC);
               end
            end
            EDRAM_S_IDLE: begin
               if (tdone) begin
                  // Refresh first so a busy user cannot starve rows
                  if (ref_req || sref_req) begin // R22
                     ras_only_reg <= ref_ras_only && !sref_req;
                     state_reg <= (ref_ras_only && !sref_req) ?
                        EDRAM_S_ROW : EDRAM_S_CBR_C;
                     tload <= 1'b1;
                     tcount <= (ref_ras_only && !sref_req) ?
                        CNT_W'(RAS_CYC) : CNT_W'(CSR_CYC);
                  end else if (req_valid) begin
                     op_reg <= req_op;
                     addr_reg <= req_addr;
                     wdata_reg <= req_wdata;
                     ras_only_reg <= 1'b0;
                     state_reg <= EDRAM_S_ROW;
                     tload <= 1'b1;
                     tcount <= CNT_W'(RCD_CYC); // R12
                  end
               end
            end
            EDRAM_S_ROW: begin
               if (tdone) begin
                  if (ras_only_reg) begin // R21
                     state_reg <= EDRAM_S_PRE;
                     tload <= 1'b1;
                     tcount <= CNT_W'(RP_CYC);
                  end else begin
                     state_reg <= EDRAM_S_COL;
                     tload <= 1'b1;
                     // Reads wait the longest access; writes the pulse
                     tcount <= (op_reg == EDRAM_OP_WRITE) ?
                        CNT_W'(CAS_CYC) : CNT_W'(ACC_CYC + SYNC_CYC); // R10
                  end
               end
            end
            EDRAM_S_COL: begin
               if (tdone) begin
                  tload <= 1'b1;
                  if (op_reg == EDRAM_OP_RMW) begin
                     state_reg <= EDRAM_S_RMWR;
                     tcount <= CNT_W'(CWD_CYC); // R5
                  end else begin
                     state_reg <= EDRAM_S_END;
                     tcount <= CNT_W'(RAS_CYC);
                  end
               end
            end
            EDRAM_S_RMWR: begin
               if (tdone) begin
                  state_reg <= EDRAM_S_WRD;
                  tload <= 1'b1;
                  tcount <= CNT_W'(WP_CYC); // R8
               end
            end
            EDRAM_S_WRD: begin
               if (tdone) begin
                  state_reg <= EDRAM_S_END;
                  tload <= 1'b1;
                  tcount <= CNT_W'(CHR_CYC);
               end
            end
            EDRAM_S_END: begin
               if (tdone) begin
                  state_reg <= EDRAM_S_PRE;
                  tload <= 1'b1;
                  tcount <= CNT_W'(RP_CYC);
               end
            end
            EDRAM_S_PRE: begin
               if (tdone && !init_done) begin // R2
                  state_reg <= EDRAM_S_CBR_C;
                  tload <= 1'b1;
                  tcount <= CNT_W'(CSR_CYC);
               end else if (tdone) begin
                  state_reg <= EDRAM_S_IDLE;
               end
            end
            EDRAM_S_CBR_C: begin
               if (tdone) begin // R14
                  state_reg <= EDRAM_S_CBR_R;
                  sleep_reg <= sref_req && init_done;
                  tload <= 1'b1;
                  tcount <= sref_req && init_done ?
                     CNT_W'(SREF_CYCLES) : CNT_W'(RAS_CYC);
               end
            end
            EDRAM_S_CBR_R: begin
               // Sleep entry holds strobes the full pulse, never between
               if (tdone) begin // R15 R16
                  if (!init_done) begin
                     init_cnt_reg <= init_cnt_reg + 4'h1;
                     if (init_cnt_reg == 4'(INIT_CYCLES - 1)) begin // R3
                        init_done <= 1'b1;
                     end
                  end
                  tload <= 1'b1;
                  // A full sleep pulse always leaves by the long precharge
                  if (sleep_reg) begin
                     state_reg <= EDRAM_S_SREF;
                     tcount <= '0;
                  end else begin
                     state_reg <= EDRAM_S_PRE;
                     tcount <= CNT_W'(RP_CYC);
                  end
               end
            end
            EDRAM_S_SREF: begin
               if (!sref_req) begin
                  state_reg <= EDRAM_S_SPRE;
                  tload <= 1'b1;
                  tcount <= CNT_W'(SREF_PRE_CYC); // R17
               end
            end
            EDRAM_S_SPRE: begin
               if (tdone) begin
                  // A CBR right after exit; further refresh is the user's
                  state_reg <= EDRAM_S_CBR_C; // R18 R19 R20
                  tload <= 1'b1;
                  tcount <= CNT_W'(CSR_CYC);
               end
            end
            default: begin
               state_reg <= EDRAM_S_IDLE;
            end
         endcase
      end
   end

   // ========================================
   // Pin drive, all from flip-flops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ras_n <= 1'b1;
         cas_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
      end else begin
         ras_n <= !(state_reg inside {EDRAM_S_ROW, EDRAM_S_COL,
            EDRAM_S_RMWR, EDRAM_S_WRD, EDRAM_S_END, EDRAM_S_CBR_R,
            EDRAM_S_SREF});
         cas_n <= !(state_reg inside {EDRAM_S_COL, EDRAM_S_RMWR,
            EDRAM_S_WRD, EDRAM_S_CBR_C, EDRAM_S_CBR_R, EDRAM_S_SREF}
            || (state_reg == EDRAM_S_END && !ras_only_reg));
         // Early write: strobe down with the row, before the column
         we_n <= !((op_reg == EDRAM_OP_WRITE && !ras_only_reg
            && state_reg inside {EDRAM_S_ROW, EDRAM_S_COL}) // R4 R13
            || state_reg == EDRAM_S_WRD); // R8
         oe_n <= !(op_reg != EDRAM_OP_WRITE
            && state_reg inside {EDRAM_S_COL, EDRAM_S_RMWR}); // R9
         // Row before column strobe, column bits after it
         addr <= (state_reg inside {EDRAM_S_IDLE, EDRAM_S_PRE,
            EDRAM_S_ROW}) ? addr_reg[ROW_W+COL_W-1:COL_W]
            : {1'b0, addr_reg[COL_W-1:0]}; // R1
         dq_out <= wdata_reg; // R7
         dq_oe <= (op_reg == EDRAM_OP_WRITE && !ras_only_reg
            && state_reg inside {EDRAM_S_ROW, EDRAM_S_COL})
            || state_reg == EDRAM_S_WRD; // R9
      end
   end

   // ========================================
   // Read data capture at the end of the access wait
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data <= '0;
         rd_valid <= 1'b0;
         ref_ack <= 1'b0;
         sref_active <= 1'b0;
      end else begin
         // Data sampled while strobes still low, so it is held
         rd_valid <= state_reg == EDRAM_S_COL && tdone
            && op_reg != EDRAM_OP_WRITE; // R6 R11
         if (state_reg == EDRAM_S_COL && tdone) begin
            rd_data <= dq_s2_reg; // R10
         end
         ref_ack <= (state_reg == EDRAM_S_CBR_R && tdone && init_done)
            || (state_reg == EDRAM_S_ROW && ras_only_reg && tdone);
         sref_active <= state_reg == EDRAM_S_SREF;
      end
   end
endmodule

// ===== edram_pkg.sv
// Package of pin widths, timing constants and states for the DRAM host
package edram_pkg;
   // ========================================
   // Clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int CLK_FREQ_KHZ = 10000;

   // ========================================
   // Geometry
   localparam int ROW_W = 11;
   localparam int COL_W = 10;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int ROWS = 2048;
   localparam int INIT_CYCLES = 8;

   // ========================================
   // Times as printed, in their own units
   localparam int T_PWRUP_US = 200;
   localparam int T_SREF_ENTRY_US = 100;
   localparam int T_SREF_FORBID_LO_US = 10;
   localparam int T_SREF_EXIT_PRE_NS = 110;
   localparam int T_RP_NS = 40;
   localparam int T_RAS_NS = 60;
   localparam int T_RCD_NS = 20;
   localparam int T_CAS_NS = 15;
   localparam int T_CSR_NS = 5;
   localparam int T_CHR_NS = 10;
   localparam int T_WP_NS = 10;
   localparam int T_CWD_NS = 37;
   localparam int T_ACC_NS = 35;
   localparam int T_DIST_REF_NS = 15600;

   // ========================================
   // Cycle counts: least times round up, never below one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   function automatic int cyc_dn(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PWRUP_CYC = T_PWRUP_US * CLK_FREQ_KHZ / 1000;
   localparam int SREF_ENTRY_CYC = T_SREF_ENTRY_US * CLK_FREQ_KHZ / 1000;
   localparam int SREF_PRE_CYC = cyc_up(T_SREF_EXIT_PRE_NS);
   localparam int RP_CYC = cyc_up(T_RP_NS);
   localparam int RAS_CYC = cyc_up(T_RAS_NS);
   localparam int RCD_CYC = cyc_up(T_RCD_NS);
   localparam int CAS_CYC = cyc_up(T_CAS_NS);
   localparam int CSR_CYC = cyc_up(T_CSR_NS);
   localparam int CHR_CYC = cyc_up(T_CHR_NS);
   localparam int WP_CYC = cyc_up(T_WP_NS);
   localparam int CWD_CYC = cyc_up(T_CWD_NS);
   localparam int ACC_CYC = cyc_up(T_ACC_NS);
   localparam int DIST_REF_CYC = cyc_dn(T_DIST_REF_NS);
   localparam int CNT_W = 16;

   // ========================================
   // Operations and states
   typedef enum logic [1:0] {
      EDRAM_OP_READ = 2'b00,
      EDRAM_OP_WRITE = 2'b01,
      EDRAM_OP_RMW = 2'b10
   } edram_op_e;

   typedef enum logic [3:0] {
      EDRAM_S_PWRUP = 4'b0000,
      EDRAM_S_IDLE = 4'b0001,
      EDRAM_S_ROW = 4'b0010,
      EDRAM_S_COL = 4'b0011,
      EDRAM_S_RMWR = 4'b0100,
      EDRAM_S_WRD = 4'b0101,
      EDRAM_S_END = 4'b0110,
      EDRAM_S_PRE = 4'b0111,
      EDRAM_S_CBR_C = 4'b1000,
      EDRAM_S_CBR_R = 4'b1001,
      EDRAM_S_SREF = 4'b1010,
      EDRAM_S_SPRE = 4'b1011
   } edram_state_e;
endpackage

// ===== edram_timer.sv
// Down counter used for every strobe interval of the host
module edram_timer
   import edram_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic load, // Start a new interval
   input wire logic [W-1:0] count, // Cycles in the interval
   output logic done // High once the interval has run out
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= count;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign done = (cnt_reg == '0) && !load;
endmodule

// ===== edram_mem_model.sv
// Behavioural EDO DRAM partner model for the host bench
module edram_mem_model
   import edram_pkg::*;
#(
   parameter int SREF_NS = 1000
) (
   input wire logic ras_n, // Row strobe
   input wire logic cas_n, // Column strobe
   input wire logic we_n, // Write strobe
   input wire logic oe_n, // Output enable
   input wire logic [ADDR_W-1:0] addr, // Multiplexed address
   input wire logic [DATA_W-1:0] dq_out, // Host data
   input wire logic dq_oe, // Host drives data
   output logic [DATA_W-1:0] dq_in, // Data back to host
   output logic [ROW_W-1:0] row_q, // Latched row
   output logic [COL_W-1:0] col_q, // Latched column
   output int cbr_cnt, // CAS-before-RAS refreshes
   output int ros_cnt, // RAS-only refreshes
   output int sref_cnt // Self refresh periods
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [logic [ROW_W+COL_W-1:0]];
   logic [DATA_W-1:0] rd_val;
   logic cbr, col_seen, early, acc_ok;
   time t_fall;
   initial begin
      cbr_cnt = 0;
      ros_cnt = 0;
      sref_cnt = 0;
      cbr = 0;
      col_seen = 1;
      early = 0;
      acc_ok = 0;
      rd_val = '0;
      row_q = '0;
      col_q = '0;
   end
   // ========================================
   // Strobe decode
   always @(negedge ras_n) begin
      t_fall = $time;
      // Pins move on the same edge, so look once they have landed
      #1;
      cbr = !cas_n;
      col_seen = 0;
      if (!cas_n) cbr_cnt++;
      else row_q = addr;
   end
   always @(posedge ras_n) begin
      if (cbr && ($time - t_fall) >= SREF_NS) sref_cnt++;
      if (!cbr && !col_seen) ros_cnt++;
   end
   always @(negedge cas_n) if (!ras_n) begin
      #1;
      col_q = addr[COL_W-1:0];
      col_seen = 1;
      early = !we_n;
      acc_ok = 0;
      #(T_ACC_NS);
      rd_val = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : '0;
      acc_ok = !cas_n;
   end
   always @(posedge cas_n) acc_ok = 0;
   // Sample just after the edge so same-edge host updates have landed
   always @(negedge cas_n or negedge we_n) begin
      #2;
      if (!ras_n && !cas_n && !we_n && dq_oe)
         mem[{row_q, col_q}] = dq_out;
   end
   // ========================================
   // Pins show the inverse when released, so a stale sample fails
   assign dq_in = (acc_ok && !ras_n && !oe_n && we_n && !early) ?
                  rd_val : ~rd_val;
endmodule

// ===== edram_host_sva.sv
// Assertion checker for the EDO DRAM host strobe timing
module edram_host_sva
   import edram_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC,
   parameter int SREF_CYCLES = SREF_ENTRY_CYC
) (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic req_valid, // Access request
   input wire edram_op_e req_op, // Operation
   input wire logic req_ready, // Request taken
   input wire logic rd_valid, // Read data pulse
   input wire logic sref_active, // In self refresh
   input wire logic init_done, // Power-up complete
   input wire logic ras_n, // Row strobe
   input wire logic cas_n, // Column strobe
   input wire logic we_n, // Write strobe
   input wire logic oe_n, // Output enable
   input wire logic [DATA_W-1:0] dq_out, // Host data
   input wire logic dq_oe // Host drives data
);
   logic [15:0] pw_cnt, ras_lo;
   logic [3:0] init_ras;
   logic sref_seen;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ========================================
   // Helper counters
   always_ff @(posedge sys_clk) begin
      if (!rst_n) pw_cnt <= '0;
      else if (pw_cnt != 16'hffff) pw_cnt <= pw_cnt + 16'h0001;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) init_ras <= '0;
      else if ($fell(ras_n) && !init_done && init_ras != 4'hf)
         init_ras <= init_ras + 4'h1;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n || ras_n) ras_lo <= '0;
      else ras_lo <= ras_lo + 16'h0001;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n || ras_n) sref_seen <= 1'b0;
      else if (sref_active) sref_seen <= 1'b1;
   end
   // ========================================
   // Properties
   sequence s_cbr_start;
      !cas_n ##1 ($fell(ras_n) && !cas_n);
   endsequence
   sequence s_sref_end;
      $rose(ras_n) && sref_seen;
   endsequence
   property p_cbr_setup;
      $fell(ras_n) && !cas_n |-> $past(cas_n) == 1'b0;
   endproperty
   property p_cbr_hold;
      s_cbr_start |=> !cas_n;
   endproperty
   property p_init_wait;
      !ras_n |-> pw_cnt >= 16'(PWRUP_CYCLES - 1);
   endproperty
   property p_init_cbr;
      $fell(ras_n) && !init_done |-> !cas_n;
   endproperty
   property p_init_cnt;
      $rose(init_done) |-> init_ras >= 4'(INIT_CYCLES);
   endproperty
   property p_early_wr;
      $fell(cas_n) && dq_oe |-> $past(we_n) == 1'b0;
   endproperty
   property p_wr_hold;
      $fell(cas_n) && dq_oe |=> dq_oe && $stable(dq_out);
   endproperty
   property p_oe_off;
      dq_oe |-> oe_n;
   endproperty
   property p_read_we;
      !oe_n |-> we_n;
   endproperty
   property p_rd_answer;
      req_valid && req_ready && req_op == EDRAM_OP_READ |-> ##[2:12] rd_valid;
   endproperty
   property p_sref_len;
      s_sref_end |-> ras_lo >= 16'(SREF_CYCLES);
   endproperty
   property p_sref_pre;
      s_sref_end |-> ras_n [*3];
   endproperty
   a_cbr_setup: assert property (p_cbr_setup)
      else $error("CAS not set up before RAS in refresh");
   a_cbr_hold: assert property (p_cbr_hold)
      else $error("CAS not held after RAS in refresh");
   a_init_wait: assert property (p_init_wait)
      else $error("RAS low before power-up wait");
   a_init_cbr: assert property (p_init_cbr)
      else $error("Init cycle is not CAS-before-RAS");
   a_init_cnt: assert property (p_init_cnt)
      else $error("Too few init cycles");
   a_early_wr: assert property (p_early_wr)
      else $error("Write strobe late in early write");
   a_wr_hold: assert property (p_wr_hold)
      else $error("Write data not held after CAS");
   a_oe_off: assert property (p_oe_off)
      else $error("Host drives data with OE on");
   a_read_we: assert property (p_read_we)
      else $error("Write strobe low during read");
   a_rd_answer: assert property (p_rd_answer)
      else $error("Read data pulse missing");
   a_sref_len: assert property (p_sref_len)
      else $error("Self refresh pulse too short");
   a_sref_pre: assert property (p_sref_pre)
      else $error("Self refresh precharge too short");
endmodule

bind edram_host edram_host_sva #(
   .PWRUP_CYCLES(PWRUP_CYCLES),
   .SREF_CYCLES(SREF_CYCLES)
) u_sva (
   .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
   .req_op(req_op), .req_ready(req_ready), .rd_valid(rd_valid),
   .sref_active(sref_active), .init_done(init_done), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .dq_out(dq_out),
   .dq_oe(dq_oe)
);

// ===== edram_host_test.sv
// Self-checking testbench for the EDO DRAM host
module edram_host_test
   import edram_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = 20, SR = 10, LIMIT = 3000;
   logic sys_clk, rst_n, req_valid, req_ready, rd_valid, ref_req;
   logic ref_ras_only, ref_ack, sref_req, sref_active, init_done;
   logic ras_n, cas_n, we_n, oe_n, dq_oe;
   edram_op_e req_op;
   logic [ROW_W+COL_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata, rd_data, dq_in, dq_out;
   logic [ADDR_W-1:0] addr;
   logic [ROW_W-1:0] row_q;
   logic [COL_W-1:0] col_q;
   int cbr_cnt, ros_cnt, sref_cnt, error_cnt, cmp_count, cyc;
   edram_host #(.PWRUP_CYCLES(PW), .SREF_CYCLES(SR)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .ref_req(ref_req), .ref_ras_only(ref_ras_only), .ref_ack(ref_ack),
      .sref_req(sref_req), .sref_active(sref_active),
      .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .oe_n(oe_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));
   edram_mem_model #(.SREF_NS(SR * CLK_PERIOD_NS)) u_mem (
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
      .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
      .row_q(row_q), .col_q(col_q), .cbr_cnt(cbr_cnt),
      .ros_cnt(ros_cnt), .sref_cnt(sref_cnt));
   initial begin
      sys_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   end
   // ========================================
   // Shared tasks
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         $display("Error run limit reached");
         print_verdict;
      end
   end
   task automatic access(input edram_op_e op, input logic [20:0] a,
                         input logic [7:0] wd, output logic [7:0] rd);
      int n;
      rd = '0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_wdata <= wd;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (req_ready === 1'b1) break;
      end
      check("req_ready", req_ready, 1'b1);
      req_valid <= 1'b0;
      if (op != EDRAM_OP_WRITE) begin
         for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (rd_valid === 1'b1) break;
         end
         rd = rd_data;
         check("rd_valid", rd_valid, 1'b1);
      end
   endtask
   task automatic refresh(input logic ro);
      int n;
      @(posedge sys_clk);
      ref_req <= 1'b1;
      ref_ras_only <= ro;
      for (n = 0; n < 100 && ref_ack !== 1'b1; n++) @(posedge sys_clk);
      check("ref_ack", ref_ack, 1'b1);
      ref_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
   // ========================================
   // Scenarios
   task automatic t_init;
      for (int n = 0; n < 300 && init_done !== 1'b1; n++)
         @(posedge sys_clk);
      check("init_done", init_done, 1'b1);
      check("init cbr", cbr_cnt, INIT_CYCLES);
      check("init ras only", ros_cnt, 0);
   endtask
   task automatic t_write_read;
      logic [20:0] a [3] = '{21'h000000, 21'h1fffff, 21'h155aaa};
      logic [7:0] d [3] = '{8'h5a, 8'hc3, 8'h0f};
      logic [7:0] r;
      for (int i = 0; i < 3; i++) access(EDRAM_OP_WRITE, a[i], d[i], r);
      for (int i = 0; i < 3; i++) begin
         access(EDRAM_OP_READ, a[i], 8'h00, r);
         check("rd_data", r, d[i]);
      end
      check("row", row_q, a[2][20:10]);
      check("col", col_q, a[2][9:0]);
   endtask
   task automatic t_rmw;
      logic [7:0] r;
      access(EDRAM_OP_RMW, 21'h000000, 8'h99, r);
      check("rmw old", r, 8'h5a);
      access(EDRAM_OP_READ, 21'h000000, 8'h00, r);
      check("rmw new", r, 8'h99);
   endtask
   task automatic t_refresh;
      int c0, r0;
      logic [7:0] r;
      c0 = cbr_cnt;
      r0 = ros_cnt;
      refresh(1'b0);
      check("cbr seen", cbr_cnt > c0, 1'b1);
      refresh(1'b1);
      check("ras only seen", ros_cnt > r0, 1'b1);
      access(EDRAM_OP_READ, 21'h1fffff, 8'h00, r);
      check("data kept", r, 8'hc3);
   endtask
   task automatic t_sref;
      logic [7:0] r;
      @(posedge sys_clk);
      sref_req <= 1'b1;
      for (int n = 0; n < 100 && sref_active !== 1'b1; n++)
         @(posedge sys_clk);
      check("sref_active", sref_active, 1'b1);
      repeat (SR + 5) @(posedge sys_clk);
      sref_req <= 1'b0;
      for (int n = 0; n < 100 && sref_active !== 1'b0; n++)
         @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      check("sref periods", sref_cnt, 1);
      access(EDRAM_OP_READ, 21'h155aaa, 8'h00, r);
      check("after sref", r, 8'h0f);
   endtask
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = EDRAM_OP_READ;
      req_addr = '0;
      req_wdata = '0;
      ref_req = 1'b0;
      ref_ras_only = 1'b0;
      sref_req = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_init;
      t_write_read;
      t_rmw;
      t_refresh;
      t_sref;
      print_verdict;
   end
endmodule
